// >>> logic/spimsc_pkg.sv
// package for the serial master/slave controller: constants, pin and config
// structs, master sequencer states, gray-code helpers.
// assumes one system clock; software config bits arrive on that clock.
package spimsc_pkg;

  // ==========================================================================
  // widths and depths
  localparam int W = 8;
  localparam int DEPTH = 128;
  localparam int AW = 7;
  localparam int PW = 8;
  localparam logic [PW-1:0] PTR_FULL = 8'h80;

  // ==========================================================================
  // data and timing constants
  localparam logic [W-1:0] FILL_BYTE = 8'hFF;
  localparam logic [8:0] HALF_MIN = 9'h004;
  localparam logic [8:0] GAP_CYC = 9'h008;
  localparam logic [8:0] CNT_ONE = 9'h001;
  localparam logic [4:0] EDGE_ONE = 5'h01;
  localparam logic [4:0] EDGE_BASE = 5'h02;

  // ==========================================================================
  // types
  typedef struct packed {
    logic master;
    logic cpol;
    logic cpha;
    logic lsb_first;
    logic continuous;
    logic [2:0] len_m1;
    logic [7:0] div;
    logic [1:0] cs_sel;
    logic [1:0] rx_sel;
  } spimsc_cfg_s;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic [3:0] rx;
  } spimsc_pin_s;

  typedef enum logic [2:0] {
    M_IDLE = 3'b000,
    M_SETUP = 3'b001,
    M_RUN = 3'b010,
    M_TAIL = 3'b011,
    M_GAP = 3'b100
  } spimsc_mst_e;

  // ==========================================================================
  // gray conversion for pointers crossing between sides
  function automatic logic [PW-1:0] bin2gray(input logic [PW-1:0] b);
    return b ^ (b >> 1);
  endfunction : bin2gray

  function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
    logic [PW-1:0] b;
    b[PW-1] = g[PW-1];
    for (int i = PW - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction : gray2bin

endpackage : spimsc_pkg

// >>> logic/spimsc_fifo.sv
// 128-byte fifo with registered read port; pointers cross as gray code
// through two sampling stages so either side may later move to its own clock.
// assumes both sides share sys_clk today.
`timescale 1ns/1ps
module spimsc_fifo
  import spimsc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic wr_valid,
  input wire logic [spimsc_pkg::W-1:0] wr_data,
  output logic wr_ready,
  output logic rd_valid,
  output logic [spimsc_pkg::W-1:0] rd_data,
  input wire logic rd_ready
);
  import spimsc_pkg::*;

  logic [W-1:0] mem_q [DEPTH];
  logic [PW-1:0] wptr_q, wptr_d, rptr_q, rptr_d;
  logic [PW-1:0] wgray_q, wgray_d, rgray_q, rgray_d;
  logic [PW-1:0] wg1_q, wg2_q, rg1_q, rg2_q;
  logic wr_ready_q, wr_ready_d, rd_valid_q, rd_valid_d;
  logic [W-1:0] rd_data_q, rd_data_d;
  logic do_wr, do_rd;

  // ==========================================================================
  // pointer arithmetic; full is judged against the synchronised read pointer,
  // so it may stay full a few cycles longer than needed, never less
  always_comb begin
    do_wr = wr_valid && wr_ready_q;
    wptr_d = wptr_q + PW'(do_wr);
    wgray_d = bin2gray(wptr_d);
    wr_ready_d = (wptr_d - gray2bin(rg2_q)) != PTR_FULL;
    do_rd = (!rd_valid_q || rd_ready) && (rptr_q != gray2bin(wg2_q));
    rptr_d = rptr_q + PW'(do_rd);
    rd_valid_d = do_rd || (rd_valid_q && !rd_ready);
    // the writer sees words handed out, not words moved into the read
    // register, so that register counts toward the 128 and never adds one
    rgray_d = bin2gray(rptr_d - PW'(rd_valid_d));
    rd_data_d = do_rd ? mem_q[rptr_q[AW-1:0]] : rd_data_q;
  end

  // pointers, double sampled gray copies and read register
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wptr_q <= '0;
      rptr_q <= '0;
      wgray_q <= '0;
      rgray_q <= '0;
      wg1_q <= '0;
      wg2_q <= '0;
      rg1_q <= '0;
      rg2_q <= '0;
      wr_ready_q <= 1'b1;
      rd_valid_q <= 1'b0;
      rd_data_q <= '0;
    end else begin
      wptr_q <= wptr_d;
      rptr_q <= rptr_d;
      wgray_q <= wgray_d;
      rgray_q <= rgray_d;
      wg1_q <= wgray_q;
      wg2_q <= wg1_q;
      rg1_q <= rgray_q;
      rg2_q <= rg1_q;
      wr_ready_q <= wr_ready_d;
      rd_valid_q <= rd_valid_d;
      rd_data_q <= rd_data_d;
    end
  end

  // storage has no reset; contents are only read behind a valid pointer
  always_ff @(posedge sys_clk) begin
    if (do_wr) begin
      mem_q[wptr_q[AW-1:0]] <= wr_data;
    end
  end

  assign wr_ready = wr_ready_q;
  assign rd_valid = rd_valid_q;
  assign rd_data = rd_data_q;

endmodule : spimsc_fifo

// >>> logic/spimsc_ctrl.sv
// serial master/slave controller: pad synchroniser, serial front end,
// master clock and select sequencer, transmit and receive fifos.
// assumes pins are resolved outside; config ports are steady during use.
// Function
// - four selects, four receive lines, one transmit
// - four-wire full-duplex clock, select, rx, tx
// - master drives clock and select, slave receives
// - separate 128-byte transmit and receive fifos
// - clock rate programmable only as master
// - programmable word length and continuous mode
// - launch and sample on opposite clock edges
// - phase 0 sample rising, phase 1 falling
// - front end timed from pad clock always
// - clock edge while selected starts shifting both
// - per word push rx, pop tx, until deselect
// - master clock divides reference, master only
// - master asserts select before clock toggles
// - transmit not-empty starts master transaction
// - stop clock, drop select when drained
// - gray pointers double sampled across domains
`timescale 1ns/1ps
module spimsc_ctrl
  import spimsc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire spimsc_pkg::spimsc_cfg_s cfg,
  input wire logic tx_wr_valid,
  input wire logic [spimsc_pkg::W-1:0] tx_wr_data,
  output logic tx_wr_ready,
  output logic rx_rd_valid,
  output logic [spimsc_pkg::W-1:0] rx_rd_data,
  input wire logic rx_rd_ready,
  input wire spimsc_pkg::spimsc_pin_s pin_i,
  output logic sclk_o,
  output logic sclk_oe_n,
  output logic [3:0] cs_n_o,
  output logic [3:0] cs_n_oe_n,
  output logic tx_o,
  output logic tx_oe_n,
  output logic busy
);
  import spimsc_pkg::*;

  // ==========================================================================
  // bit picked for the line: top bit of the word or bit zero
  function automatic logic txbit(input logic [W-1:0] sh, input logic [2:0] len,
                                 input logic lsb);
    return lsb ? sh[0] : sh[len];
  endfunction : txbit

  spimsc_pin_s pin_m_q, pin_s_q;
  logic sclk_prev_q, sel_prev_q, have_q, have_d;
  logic [W-1:0] sh_q, sh_d, rsh_q, rsh_d, rxw_q, rxw_d;
  logic [2:0] bits_q, bits_d;
  logic tx_o_q, tx_o_d, tx_oe_n_q, rx_push_q, push;
  logic rise, fall, samp, launch, sel, rxbit, load, tx_evt;
  logic tx_rd_valid, tx_rd_ready;
  logic [W-1:0] tx_rd_data;
  spimsc_mst_e mst_q, mst_d;
  logic [8:0] cnt_q, cnt_d, half;
  logic [4:0] edge_q, edge_d, edge_full;
  logic sclk_q, sclk_d, cs_act_q, cs_act_d;
  logic [3:0] cs_n_q, cs_n_d;
  logic sclk_oe_n_q, busy_q;
  logic [3:0] cs_oe_n_q;

  // ==========================================================================
  // fifos: software fills transmit, front end fills receive
  spimsc_fifo u_tx_fifo (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .wr_valid(tx_wr_valid),
    .wr_data(tx_wr_data),
    .wr_ready(tx_wr_ready),
    .rd_valid(tx_rd_valid),
    .rd_data(tx_rd_data),
    .rd_ready(tx_rd_ready)
  );

  // a full receive fifo drops the word rather than stall the link
  spimsc_fifo u_rx_fifo (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .wr_valid(rx_push_q),
    .wr_data(rxw_q),
    .wr_ready(),
    .rd_valid(rx_rd_valid),
    .rd_data(rx_rd_data),
    .rd_ready(rx_rd_ready)
  );

  // ==========================================================================
  // pad synchroniser: only the second stage is read
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_m_q <= '{sclk: 1'b0, cs_n: 1'b1, rx: 4'h0};
      pin_s_q <= '{sclk: 1'b0, cs_n: 1'b1, rx: 4'h0};
    end else begin
      pin_m_q <= pin_i;
      pin_s_q <= pin_m_q;
    end
  end

  // ==========================================================================
  // front end: clock is the pad copy in both modes so timing is identical
  always_comb begin
    rise = pin_s_q.sclk && !sclk_prev_q;
    fall = !pin_s_q.sclk && sclk_prev_q;
    samp = cfg.cpha ? fall : rise;
    launch = cfg.cpha ? rise : fall;
    sel = cfg.master ? cs_act_q : !pin_s_q.cs_n;
    rxbit = pin_s_q.rx[cfg.rx_sel];
    sh_d = sh_q;
    rsh_d = rsh_q;
    rxw_d = rxw_q;
    bits_d = bits_q;
    have_d = have_q;
    tx_o_d = tx_o_q;
    load = 1'b0;
    push = 1'b0;
    if (!sel) begin
      bits_d = '0;
      rsh_d = '0;
    end else begin
      // a word already preloaded survives a deselect and goes out next
      load = !sel_prev_q && !have_q;
      if (samp) begin
        if (cfg.lsb_first) begin
          rsh_d = rsh_q >> 1;
          rsh_d[cfg.len_m1] = rxbit;
        end else begin
          rsh_d = {rsh_q[W-2:0], rxbit};
        end
        // width must stay fixed mid-word or the count is meaningless
        if (bits_q == cfg.len_m1) begin
          push = 1'b1;
          rxw_d = rsh_d;
          rsh_d = '0;
          bits_d = '0;
          load = 1'b1;
        end else begin
          bits_d = bits_q + 3'h1;
        end
      end else if (launch && bits_q != 3'h0) begin
        // first launch edge of a word keeps the preset bit on the line
        sh_d = cfg.lsb_first ? (sh_q >> 1) : (sh_q << 1);
        tx_o_d = txbit(sh_d, cfg.len_m1, cfg.lsb_first);
      end
    end
    if (load) begin
      sh_d = tx_rd_valid ? tx_rd_data : FILL_BYTE;
      have_d = tx_rd_valid;
      tx_o_d = txbit(sh_d, cfg.len_m1, cfg.lsb_first);
    end
    tx_rd_ready = load && tx_rd_valid;
    tx_evt = launch || load;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_prev_q <= 1'b0;
      sel_prev_q <= 1'b0;
      have_q <= 1'b0;
      sh_q <= '0;
      rsh_q <= '0;
      rxw_q <= '0;
      bits_q <= '0;
      tx_o_q <= 1'b0;
      tx_oe_n_q <= 1'b1;
      rx_push_q <= 1'b0;
    end else begin
      sclk_prev_q <= pin_s_q.sclk;
      sel_prev_q <= sel;
      have_q <= have_d;
      sh_q <= sh_d;
      rsh_q <= rsh_d;
      rxw_q <= rxw_d;
      bits_q <= bits_d;
      tx_o_q <= tx_o_d;
      tx_oe_n_q <= !sel;
      rx_push_q <= push;
    end
  end

  // ==========================================================================
  // master sequencer: half period is div plus a floor that lets the pad
  // synchroniser see every edge; below it edges would be lost
  always_comb begin
    half = {1'b0, cfg.div} + HALF_MIN;
    edge_full = {1'b0, cfg.len_m1, 1'b0} + EDGE_BASE;
    mst_d = mst_q;
    cnt_d = cnt_q;
    edge_d = edge_q;
    sclk_d = sclk_q;
    cs_act_d = cs_act_q;
    case (mst_q)
      M_IDLE: begin
        sclk_d = cfg.cpol;
        if (cfg.master && (tx_rd_valid || have_q)) begin
          cs_act_d = 1'b1;
          cnt_d = half;
          mst_d = M_SETUP;
        end
      end
      M_SETUP: begin
        if (cnt_q == CNT_ONE) begin
          cnt_d = half;
          edge_d = edge_full;
          mst_d = M_RUN;
        end else begin
          cnt_d = cnt_q - CNT_ONE;
        end
      end
      M_RUN: begin
        if (cnt_q == CNT_ONE) begin
          sclk_d = !sclk_q;
          cnt_d = half;
          edge_d = edge_q - EDGE_ONE;
          if (edge_q == EDGE_ONE) begin
            mst_d = M_TAIL;
          end
        end else begin
          cnt_d = cnt_q - CNT_ONE;
        end
      end
      M_TAIL: begin
        if (cnt_q == CNT_ONE) begin
          cnt_d = GAP_CYC;
          mst_d = M_GAP;
        end else begin
          cnt_d = cnt_q - CNT_ONE;
        end
      end
      M_GAP: begin
        // the gap lets the front end preload before deciding to go on
        if (cnt_q == CNT_ONE) begin
          if (have_q && cfg.continuous) begin
            cnt_d = half;
            edge_d = edge_full;
            mst_d = M_RUN;
          end else begin
            cs_act_d = 1'b0;
            mst_d = M_IDLE;
          end
        end else begin
          cnt_d = cnt_q - CNT_ONE;
        end
      end
      default: begin
        mst_d = M_IDLE;
      end
    endcase
    if (!cfg.master) begin
      mst_d = M_IDLE;
      cs_act_d = 1'b0;
      sclk_d = cfg.cpol;
    end
    for (int i = 0; i < 4; i++) begin
      cs_n_d[i] = !(cs_act_d && cfg.cs_sel == 2'(i));
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mst_q <= M_IDLE;
      cnt_q <= '0;
      edge_q <= '0;
      sclk_q <= 1'b0;
      cs_act_q <= 1'b0;
      cs_n_q <= 4'hF;
      sclk_oe_n_q <= 1'b1;
      cs_oe_n_q <= 4'hF;
      busy_q <= 1'b0;
    end else begin
      mst_q <= mst_d;
      cnt_q <= cnt_d;
      edge_q <= edge_d;
      sclk_q <= sclk_d;
      cs_act_q <= cs_act_d;
      cs_n_q <= cs_n_d;
      sclk_oe_n_q <= !cfg.master;
      cs_oe_n_q <= {4{!cfg.master}};
      busy_q <= sel || (mst_d != M_IDLE);
    end
  end

  // outputs straight from flops
  assign sclk_o = sclk_q;
  assign sclk_oe_n = sclk_oe_n_q;
  assign cs_n_o = cs_n_q;
  assign cs_n_oe_n = cs_oe_n_q;
  assign tx_o = tx_o_q;
  assign tx_oe_n = tx_oe_n_q;
  assign busy = busy_q;

  // ==========================================================================
  // assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  AST_CS_LEADS_CLK: assert property (
    $rose(cs_act_q) |-> ##1 $stable(sclk_q) [*3])
    else $error("clock moved too soon after select");
  AST_HALF_PERIOD: assert property (
    (mst_q == M_RUN && $changed(sclk_q)) |-> ##1 $stable(sclk_q) [*3])
    else $error("master half period shorter than floor");
  AST_SLAVE_NO_DRIVE: assert property (
    !cfg.master |=> sclk_oe_n && (&cs_n_oe_n))
    else $error("slave drives clock or select");
  AST_START: assert property (
    (mst_q == M_IDLE && cfg.master && tx_rd_valid) |=> cs_act_q && mst_q == M_SETUP)
    else $error("pending data did not start master");
  AST_STOP: assert property (
    (mst_q == M_GAP && cnt_q == CNT_ONE && !have_q) |=> !cs_act_q && cs_n_o == 4'hF)
    else $error("select held after drain");
  AST_PUSH: assert property (
    (sel && samp && bits_q == cfg.len_m1) |=> rx_push_q && bits_q == 3'h0)
    else $error("word end without push");
  AST_TX_OE: assert property (
    sel |=> !tx_oe_n)
    else $error("transmit not driven while selected");
  AST_FILL: assert property (
    (load && !tx_rd_valid) |=> sh_q == FILL_BYTE && !have_q)
    else $error("empty fifo did not give filler");
  AST_LAUNCH: assert property (
    $changed(tx_o) |-> $past(tx_evt))
    else $error("transmit changed off launch edge");

  COV_MASTER: cover property ($rose(cs_act_q) ##[1:200] $fell(cs_act_q));
  COV_CONT: cover property (rx_push_q && cfg.continuous && cfg.master);
  COV_SLAVE_FILL: cover property (load && !tx_rd_valid && !cfg.master);

endmodule : spimsc_ctrl

// >>> bench/spimsc_peer.sv
// far-side serial partner: a selected peripheral while the controller is
// master, an external master running frames while it is slave.
// assumes the bench resolves the pads and shares cfg with the controller.
`timescale 1ns/1ps
module spimsc_peer (
  input wire spimsc_pkg::spimsc_cfg_s cfg,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic [spimsc_pkg::W-1:0] reply,
  output logic dout,
  output logic m_sclk,
  output logic m_cs_n
);
  import spimsc_pkg::*;

  logic [W-1:0] got;
  logic [W-1:0] words[$];
  int cnt;
  int frames;

  // ====================
  // shifting
  // slot of the k-th bit within its word
  function automatic int slot(input int k);
    int j;
    j = k % (int'(cfg.len_m1) + 1);
    return cfg.lsb_first ? j : int'(cfg.len_m1) - j;
  endfunction : slot

  initial begin
    dout = 1'b0;
    m_sclk = 1'b0;
    m_cs_n = 1'b1;
    frames = 0;
  end

  // first bit waits on the line before any clock edge
  always @(negedge cs_n) begin
    cnt = 0;
    got = '0;
    frames++;
    dout = reply[slot(0)];
  end

  // a released line shows the inverse, so stale data cannot pass for good
  always @(posedge cs_n) dout = ~dout;

  // sample edge set by phase alone, launch on the other edge
  always @(sclk) begin
    if (!cs_n && sclk === !cfg.cpha) begin
      got[slot(cnt)] = din;
      cnt++;
      if (cnt % (int'(cfg.len_m1) + 1) == 0) begin
        words.push_back(got);
        got = '0;
      end
    end else if (!cs_n && cnt > 0) begin
      dout = reply[slot(cnt)];
    end
  end

  // ====================
  // external master frame
  // clock parked at the polarity level outside the frame
  task automatic frame();
    m_sclk = cfg.cpol;
    #833;
    m_cs_n = 1'b0;
    #800;
    repeat (2 * (int'(cfg.len_m1) + 1)) begin
      m_sclk = ~m_sclk;
      #400;
    end
    m_cs_n = 1'b1;
    #800;
  endtask : frame

endmodule : spimsc_peer

// >>> bench/tb_top.sv
// top bench: master words in four clock modes, length, order, rate and
// continuous select, then slave fill, refusal, filler and drain.
// assumes the partner model on the pads and a 10 MHz system clock.
`timescale 1ns/1ps
module tb_top;
  import spimsc_pkg::*;

  logic sys_clk, arst_n, busy, sclk_o, sclk_oe_n, tx_o, tx_oe_n;
  logic tx_wr_valid, tx_wr_ready, rx_rd_valid, rx_rd_ready;
  logic dout, m_sclk, m_cs_n, cs_pad, tx_pad, sclk_seen;
  logic [W-1:0] tx_wr_data, rx_rd_data, reply;
  logic [3:0] cs_n_o, cs_n_oe_n;
  spimsc_cfg_s cfg;
  spimsc_pin_s pin_i;
  int n_mismatch, cmp_count, cyc, run_len, half_len, m;

  // ====================
  // pads: the party whose enable is low drives the line
  assign cs_pad = cs_n_oe_n[cfg.cs_sel] ? m_cs_n : cs_n_o[cfg.cs_sel];
  assign tx_pad = tx_oe_n ? 1'bz : tx_o;
  always_comb begin
    pin_i.sclk = sclk_oe_n ? m_sclk : sclk_o;
    pin_i.cs_n = cs_pad;
    pin_i.rx = {4{~dout}};
    pin_i.rx[cfg.rx_sel] = dout;
  end

  spimsc_ctrl i_spimsc_ctrl (
    .sys_clk(sys_clk), .arst_n(arst_n), .cfg(cfg), .tx_wr_valid(tx_wr_valid),
    .tx_wr_data(tx_wr_data), .tx_wr_ready(tx_wr_ready), .rx_rd_valid(rx_rd_valid),
    .rx_rd_data(rx_rd_data), .rx_rd_ready(rx_rd_ready), .pin_i(pin_i), .sclk_o(sclk_o),
    .sclk_oe_n(sclk_oe_n), .cs_n_o(cs_n_o), .cs_n_oe_n(cs_n_oe_n), .tx_o(tx_o),
    .tx_oe_n(tx_oe_n), .busy(busy)
  );

  spimsc_peer i_spimsc_peer (
    .cfg(cfg), .sclk(pin_i.sclk), .cs_n(cs_pad), .din(tx_pad), .reply(reply),
    .dout(dout), .m_sclk(m_sclk), .m_cs_n(m_cs_n)
  );

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // half-period of the driven clock, and a ceiling on the run
  always @(posedge sys_clk) begin
    cyc++;
    run_len++;
    if (sclk_o !== sclk_seen) begin
      half_len = run_len;
      run_len = 0;
    end
    sclk_seen = sclk_o;
    if (cyc == 40000) begin
      n_mismatch++;
      stop_test();
    end
  end

  // ====================
  // shared tasks
  task automatic stop_test();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test

  task automatic check(input logic [W-1:0] got, input logic [W-1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : check

  // offer a byte, held until a ready edge takes it
  task automatic push(input logic [W-1:0] b);
    int n;
    tx_wr_valid = 1'b1;
    tx_wr_data = b;
    for (n = 0; n < 400 && tx_wr_ready !== 1'b1; n++) @(negedge sys_clk);
    check({7'h0, tx_wr_ready}, 8'h01);
    @(negedge sys_clk);
    tx_wr_valid = 1'b0;
    // let an edge pass so a following push never re-raises valid at once
    @(negedge sys_clk);
  endtask : push

  task automatic pop(input logic [W-1:0] exp);
    int n;
    for (n = 0; n < 400 && rx_rd_valid !== 1'b1; n++) @(negedge sys_clk);
    check({7'h0, rx_rd_valid}, 8'h01);
    check(rx_rd_data, exp);
    rx_rd_ready = 1'b1;
    @(negedge sys_clk);
    rx_rd_ready = 1'b0;
    // an idle edge between reads keeps ready from toggling in one step
    @(negedge sys_clk);
  endtask : pop

  // busy may rise a few cycles late, as the not-empty flag is synced
  task automatic wait_idle();
    int n;
    for (n = 0; n < 30 && busy !== 1'b1; n++) @(negedge sys_clk);
    for (n = 0; n < 3000 && busy !== 1'b0; n++) @(negedge sys_clk);
    check({7'h0, busy}, 8'h00);
    repeat (2) @(negedge sys_clk);
  endtask : wait_idle

  // ====================
  // scenarios
  // one master word: select before clocking, data both ways, clean stop
  task automatic mst_word(input logic [W-1:0] sent, input logic [W-1:0] back);
    logic [W-1:0] mask;
    int n;
    mask = 8'hff >> (3'h7 - cfg.len_m1);
    reply = back;
    i_spimsc_peer.words.delete();
    push(sent);
    for (n = 0; n < 60 && cs_pad !== 1'b0; n++) @(negedge sys_clk);
    check({cs_n_oe_n, cs_n_o}, {4'h0, ~(4'h1 << cfg.cs_sel)});
    check({6'h0, sclk_oe_n, sclk_o}, {6'h0, 1'b0, cfg.cpol});
    @(negedge sys_clk);
    check({7'h0, tx_oe_n}, 8'h00);
    wait_idle();
    check(i_spimsc_peer.words[0], sent & mask);
    check({cs_n_o, 2'h0, tx_oe_n, sclk_o}, {4'hf, 2'h0, 1'b1, cfg.cpol});
    pop(back & mask);
  endtask : mst_word

  // two words under one select
  task automatic mst_cont();
    int n;
    cfg.continuous = 1'b1;
    reply = 8'h81;
    i_spimsc_peer.words.delete();
    n = i_spimsc_peer.frames;
    push(8'h11);
    push(8'h22);
    wait_idle();
    check(8'(i_spimsc_peer.frames - n), 8'h01);
    check(i_spimsc_peer.words[1], 8'h22);
    pop(8'h81);
    pop(8'h81);
    cfg.continuous = 1'b0;
  endtask : mst_cont

  // slave: fill until refused, drain over the link, filler when empty
  task automatic slv_fill();
    int i;
    cfg.master = 1'b0;
    cfg.cpol = 1'b1;
    cfg.cpha = 1'b1;
    repeat (4) @(negedge sys_clk);
    for (i = 0; i < DEPTH; i++) push(8'(i) + 8'h40);
    check({7'h0, tx_wr_ready}, 8'h00);
    tx_wr_valid = 1'b1;
    tx_wr_data = 8'h00;
    repeat (3) @(negedge sys_clk);
    tx_wr_valid = 1'b0;
    i_spimsc_peer.words.delete();
    for (i = 0; i <= DEPTH; i++) begin
      reply = 8'(i) ^ 8'h5a;
      i_spimsc_peer.frame();
      @(negedge sys_clk);
      check(i_spimsc_peer.words[i], (i == DEPTH) ? FILL_BYTE : 8'(i) + 8'h40);
    end
    for (i = 0; i < DEPTH; i++) pop(8'(i) ^ 8'h5a);
    repeat (4) @(negedge sys_clk);
    check({7'h0, rx_rd_valid}, 8'h00);
  endtask : slv_fill

  // ====================
  // main sequence
  initial begin
    arst_n = 1'b0;
    cfg = '0;
    cfg.len_m1 = 3'h7;
    tx_wr_valid = 1'b0;
    tx_wr_data = '0;
    rx_rd_ready = 1'b0;
    reply = '0;
    sclk_seen = 1'b0;
    n_mismatch = 0;
    cmp_count = 0;
    cyc = 0;
    run_len = 0;
    half_len = 0;
    repeat (5) @(negedge sys_clk);
    check({sclk_oe_n, tx_oe_n, busy, tx_wr_ready, rx_rd_valid, 3'h0}, 8'hd0);
    check({cs_n_oe_n, cs_n_o}, 8'hff);
    arst_n = 1'b1;
    repeat (2) @(negedge sys_clk);
    cfg.master = 1'b1;
    for (m = 0; m < 4; m++) begin
      cfg.cpol = m[1];
      cfg.cpha = m[0];
      cfg.cs_sel = 2'(m);
      cfg.rx_sel = 2'(3 - m);
      repeat (3) @(negedge sys_clk);
      mst_word(8'h96 + 8'(m), 8'h3c ^ 8'(m));
    end
    cfg.lsb_first = 1'b1;
    cfg.len_m1 = 3'h3; // width changed only while idle
    mst_word(8'hb2, 8'h0d);
    cfg.lsb_first = 1'b0;
    cfg.len_m1 = 3'h7;
    cfg.div = 8'h03;
    mst_word(8'h5a, 8'hc3);
    check(half_len[7:0], cfg.div + 8'h04);
    cfg.div = 8'h00;
    mst_cont();
    slv_fill();
    stop_test();
  end

endmodule : tb_top
